//--- aps_power_selftest_regs.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// R1 - host zeroes startup register after reset
// R2 - storage byte reads back, affects nothing
// R3 - bits 2:0 pick wake power level
// R4 - bits 6:4 pick watch power level
// R5 - fast serial enable always reads zero
// R6 - host enables fast serial by sequence
// R7 - x bits 2/3 drive positive/negative
// R8 - x writes: bit0 one, others zero
// R9 - y bits 2/3 drive positive/negative
// R10 - y writes keep reserved bits zero
// R11 - y bit7 written after x bit0
// R12 - y reads 0x80 running, 0x00 idle
// R13 - watch activity moves to continuous wake
// R14 - power register bit 3 reads zero
module aps_power_selftest_regs
	import aps_pkg::*;
(
	// clocking
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	// operating mode field, same clock
	input  wire logic [2:0]        modeCode,
	input  wire logic              modeLoad,
	// activity detector, asynchronous pin level
	input  wire logic              activityPin,
	// device side results
	output aps_mode_t              operatingMode,
	output aps_levels_t            powerLevels,
	output aps_drive_t             testDrive,
	output logic                   fastSerialEnable,
	output logic      [REG_W-1:0]  startupFixup
);

	// register state
	logic [REG_W-1:0] freeStorage;
	logic [REG_W-1:0] next_startupFixup;
	logic [REG_W-1:0] next_freeStorage;
	logic [2:0]       next_wakeLevel;
	logic [2:0]       next_watchLevel;
	logic [2:0]       next_activeLevel;
	logic             next_fastSerialEnable;
	aps_drive_t       next_testDrive;
	aps_mode_t        next_operatingMode;

	// bus state
	logic [DATA_W-1:0] next_prdata;
	logic              next_pready;
	logic              next_pslverr;

	// decode helpers
	logic        activitySync;
	logic        accessDone;
	logic        writeByte;
	logic        mapped;
	logic [7:0]  wrByte;
	logic [7:0]  readByte;
	logic        modeRunning;

	// activity is a pin level, so synchronise before use
	aps_sync #(
		.WIDTH (1)
	) uActivitySync (
		.clk     (clk),
		.srst    (srst),
		.ce      (ce),
		.asyncIn (activityPin),
		.syncOut (activitySync)
	);

	// write takes effect only at the edge that completes the access
	assign accessDone = psel && penable && pready;
	assign writeByte  = accessDone && pwrite && pstrb[0];
	assign wrByte     = pwdata[7:0];

	// modes in which the sensor is running
	assign modeRunning = (operatingMode != MODE_SLEEP) &&
		(operatingMode != MODE_STANDBY);

	// address map and read mux
	always_comb begin
		mapped   = 1'b1;
		readByte = 8'h00;
		if (regHit(paddr, IDX_STARTUP_FIXUP)) begin
			// R1 startup register readable
			readByte = startupFixup;
		end else if (regHit(paddr, IDX_FREE_STORAGE)) begin
			// R2 storage readback
			readByte = freeStorage;
		end else if (regHit(paddr, IDX_POWER_LEVEL)) begin
			// R5 fast enable hidden
			readByte[FAST_BIT] = 1'b0;
			// R14 reserved reads zero
			readByte[RESERVED_BIT] = 1'b0;
			// R3 wake level field
			readByte[WAKE_LVL_LSB +: 3] = powerLevels.wake;
			// R4 watch level field
			readByte[WATCH_LVL_LSB +: 3] = powerLevels.watch;
		end else if (regHit(paddr, IDX_X_TEST_DRIVE)) begin
			// write only, reads as zero
			readByte = 8'h00;
		end else if (regHit(paddr, IDX_Y_TEST_DRIVE)) begin
			// R12 mode dependent readback
			readByte = modeRunning ? Y_READ_RUNNING : Y_READ_IDLE;
		end else begin
			mapped = 1'b0;
		end
	end

	// bus answer: one wait state, then pready for a single cycle
	always_comb begin
		next_pready  = psel && penable && !pready;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (next_pready) begin
			next_prdata  = pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, readByte};
			next_pslverr = !mapped;
		end
	end

	// register writes; reserved codes are stored as written
	always_comb begin
		next_startupFixup     = startupFixup;
		next_freeStorage      = freeStorage;
		next_wakeLevel        = powerLevels.wake;
		next_watchLevel       = powerLevels.watch;
		next_fastSerialEnable = fastSerialEnable;
		next_testDrive        = testDrive;
		if (writeByte && regHit(paddr, IDX_STARTUP_FIXUP)) begin
			next_startupFixup = wrByte;
		end
		// R2 store, no side effect
		if (writeByte && regHit(paddr, IDX_FREE_STORAGE)) begin
			next_freeStorage = wrByte;
		end
		if (writeByte && regHit(paddr, IDX_POWER_LEVEL)) begin
			// R3 wake level
			next_wakeLevel = wrByte[WAKE_LVL_LSB +: 3];
			// R4 watch level
			next_watchLevel = wrByte[WATCH_LVL_LSB +: 3];
			// R5 kept but never read back
			next_fastSerialEnable = wrByte[FAST_BIT];
		end
		if (writeByte && regHit(paddr, IDX_X_TEST_DRIVE)) begin
			// R7 x axis drive
			next_testDrive.xPositive = wrByte[POS_DRIVE_BIT];
			next_testDrive.xNegative = wrByte[NEG_DRIVE_BIT];
		end
		if (writeByte && regHit(paddr, IDX_Y_TEST_DRIVE)) begin
			// R9 y axis drive
			next_testDrive.yPositive = wrByte[POS_DRIVE_BIT];
			next_testDrive.yNegative = wrByte[NEG_DRIVE_BIT];
		end
	end

	// operating mode; a software load wins over a same-cycle wakeup
	always_comb begin
		next_operatingMode = operatingMode;
		if (modeLoad) begin
			next_operatingMode = modeDecode(modeCode);
		end else begin
			unique case (operatingMode)
				MODE_WATCH: begin
					// R13 activity wakes the sensor
					if (activitySync) begin
						next_operatingMode = MODE_CONTINUOUS_WAKE_MODE;
					end
				end
				MODE_SLEEP,
				MODE_STANDBY,
				MODE_CONTINUOUS_WAKE_MODE,
				MODE_COMBINED,
				MODE_ONE_SHOT_COUNT_MODE: begin
					next_operatingMode = operatingMode;
				end
			endcase
		end
	end

	// level in force for the mode being entered
	always_comb begin
		next_activeLevel = LVL_LOW;
		unique case (next_operatingMode)
			MODE_WATCH: begin
				next_activeLevel = next_watchLevel;
			end
			MODE_CONTINUOUS_WAKE_MODE,
			MODE_COMBINED: begin
				// R13 wake level after auto wake
				next_activeLevel = next_wakeLevel;
			end
			MODE_SLEEP,
			MODE_STANDBY,
			MODE_ONE_SHOT_COUNT_MODE: begin
				next_activeLevel = LVL_LOW;
			end
		endcase
	end

	// all state registers; ce low freezes everything
	always_ff @(posedge clk) begin
		if (srst) begin
			startupFixup       <= RST_STARTUP_FIXUP;
			freeStorage        <= RST_FREE_STORAGE;
			powerLevels        <= {RST_POWER_LEVEL, RST_POWER_LEVEL,
				LVL_LOW};
			fastSerialEnable   <= 1'b0;
			testDrive          <= '0;
			operatingMode      <= MODE_SLEEP;
			prdata             <= '0;
			pready             <= 1'b0;
			pslverr            <= 1'b0;
		end else if (ce) begin
			startupFixup       <= next_startupFixup;
			freeStorage        <= next_freeStorage;
			powerLevels.wake   <= next_wakeLevel;
			powerLevels.watch  <= next_watchLevel;
			powerLevels.active <= next_activeLevel;
			fastSerialEnable   <= next_fastSerialEnable;
			testDrive          <= next_testDrive;
			operatingMode      <= next_operatingMode;
			prdata             <= next_prdata;
			pready             <= next_pready;
			pslverr            <= next_pslverr;
		end
	end

endmodule

//--- aps_pkg.sv
package aps_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_STARTUP_FIXUP = 8'h1A;
	localparam logic [7:0] IDX_FREE_STORAGE  = 8'h1B;
	localparam logic [7:0] IDX_POWER_LEVEL   = 8'h1C;
	localparam logic [7:0] IDX_X_TEST_DRIVE  = 8'h20;
	localparam logic [7:0] IDX_Y_TEST_DRIVE  = 8'h21;

	// reset values
	localparam logic [7:0] RST_STARTUP_FIXUP = 8'h00;
	localparam logic [7:0] RST_FREE_STORAGE  = 8'h00;
	localparam logic [2:0] RST_POWER_LEVEL   = 3'h0;

	// power level control fields
	localparam int WAKE_LVL_LSB  = 0;
	localparam int RESERVED_BIT  = 3;
	localparam int WATCH_LVL_LSB = 4;
	localparam int FAST_BIT      = 7;

	// power level codes
	localparam logic [2:0] LVL_LOW       = 3'h0;
	localparam logic [2:0] LVL_ULTRA_LOW = 3'h3;
	localparam logic [2:0] LVL_PRECISION = 3'h4;

	// test drive fields, same place in both axis registers
	localparam int POS_DRIVE_BIT = 2;
	localparam int NEG_DRIVE_BIT = 3;

	// y register readback
	localparam logic [7:0] Y_READ_RUNNING = 8'h80;
	localparam logic [7:0] Y_READ_IDLE    = 8'h00;

	// operating mode field codes
	localparam logic [2:0] MODE_CODE_SLEEP    = 3'h0;
	localparam logic [2:0] MODE_CODE_STANDBY  = 3'h1;
	localparam logic [2:0] MODE_CODE_WATCH    = 3'h2;
	localparam logic [2:0] MODE_CODE_CONTINUOUS_WAKE_MODE    = 3'h3;
	localparam logic [2:0] MODE_CODE_COMBINED = 3'h4;
	localparam logic [2:0] MODE_CODE_ONE_SHOT_COUNT_MODE     = 3'h5;

	// operating modes
	typedef enum logic [2:0] {
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_WATCH,
		MODE_CONTINUOUS_WAKE_MODE,
		MODE_COMBINED,
		MODE_ONE_SHOT_COUNT_MODE
	} aps_mode_t;

	// sensing element drive
	typedef struct packed {
		logic xPositive;
		logic xNegative;
		logic yPositive;
		logic yNegative;
	} aps_drive_t;

	// power level selections
	typedef struct packed {
		logic [2:0] wake;
		logic [2:0] watch;
		logic [2:0] active;
	} aps_levels_t;

	// byte address hit for a register index
	function automatic logic regHit(input logic [ADDR_W-1:0] addr,
		input logic [7:0] idx);
		// index widened on purpose to the byte address width
		regHit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	// operating mode field to mode; unknown codes mean sleep
	function automatic aps_mode_t modeDecode(input logic [2:0] code);
		case (code)
			MODE_CODE_STANDBY:  modeDecode = MODE_STANDBY;
			MODE_CODE_WATCH:    modeDecode = MODE_WATCH;
			MODE_CODE_CONTINUOUS_WAKE_MODE:    modeDecode = MODE_CONTINUOUS_WAKE_MODE;
			MODE_CODE_COMBINED: modeDecode = MODE_COMBINED;
			MODE_CODE_ONE_SHOT_COUNT_MODE:     modeDecode = MODE_ONE_SHOT_COUNT_MODE;
			default:            modeDecode = MODE_SLEEP;
		endcase
	endfunction

endpackage

//--- aps_sync.sv
`timescale 1ns/1ps

module aps_sync
	import aps_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clocking
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             ce,
	// asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] firstStage;

	// two flops per bit; only the second stage is read outside
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gSync
			always_ff @(posedge clk) begin
				if (srst) begin
					firstStage[i] <= 1'b0;
					syncOut[i]    <= 1'b0;
				end else if (ce) begin
					firstStage[i] <= asyncIn[i];
					syncOut[i]    <= firstStage[i];
				end
			end
		end
	endgenerate

endmodule

//--- aps_monitor.sv
`timescale 1ns/1ps
module aps_monitor
	import aps_pkg::*;
(
	// clocking
	input logic              clk,
	input logic              srst,
	// apb
	input logic              psel,
	input logic              penable,
	input logic              pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [DATA_W-1:0] pwdata,
	input logic [DATA_W-1:0] prdata,
	input logic              pready,
	// device side
	input logic              activityPin,
	input aps_mode_t         operatingMode,
	input aps_levels_t       powerLevels,
	input aps_drive_t        testDrive
);
	// completed transfers; the bench only lowers ce with the bus idle
	logic wrDone;
	logic rdDone;
	assign wrDone = psel && penable && pready && pwrite;
	assign rdDone = psel && penable && pready && !pwrite;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	AST_STORE_QUIET: assert property (
		wrDone && paddr == 12'h06C |=> $stable(powerLevels)
		&& $stable(testDrive)) else $error("storage leaked");
	AST_WAKE_LVL: assert property (
		wrDone && paddr == 12'h070 |=> powerLevels.wake
		== $past(pwdata[2:0])) else $error("wake level");
	AST_WATCH_LVL: assert property (
		wrDone && paddr == 12'h070 |=> powerLevels.watch
		== $past(pwdata[6:4])) else $error("watch level");
	AST_POWER_READ: assert property (
		rdDone && paddr == 12'h070 |-> !prdata[7] && !prdata[3])
		else $error("power readback");
	AST_X_DRIVE: assert property (
		wrDone && paddr == 12'h080 |=> testDrive.xPositive
		== $past(pwdata[2]) && testDrive.xNegative == $past(pwdata[3]))
		else $error("x drive");
	AST_Y_DRIVE: assert property (
		wrDone && paddr == 12'h084 |=> testDrive.yPositive
		== $past(pwdata[2]) && testDrive.yNegative == $past(pwdata[3]))
		else $error("y drive");
	AST_Y_READ: assert property (
		rdDone && paddr == 12'h084 |-> prdata == ((operatingMode
		inside {MODE_SLEEP, MODE_STANDBY}) ? 32'h0 : 32'h80))
		else $error("y readback");
	AST_WAKEUP: assert property (
		$rose(activityPin) && operatingMode == MODE_WATCH
		|-> ##[1:4] operatingMode == MODE_CONTINUOUS_WAKE_MODE) else $error("no wakeup");
endmodule

bind aps_power_selftest_regs aps_monitor aps_monitor_inst (.clk,
	.srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.activityPin, .operatingMode, .powerLevels, .testDrive);

//--- aps_host.sv
`timescale 1ns/1ps
module aps_host
	import aps_pkg::*;
(
	// answer
	input  logic              clk,
	input  logic [DATA_W-1:0] prdata,
	input  logic              pready,
	input  logic              pslverr,
	// request
	output logic              psel,
	output logic              penable,
	output logic              pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [DATA_W-1:0] pwdata
);
	// last answer seen
	logic [DATA_W-1:0] q;
	logic              e;

	// bus idle from time zero
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= '0;
		pwdata <= '0;
	end

	// one transfer held until pready; idle edge after avoids double drive
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// whole level write; fast bit never read back
	task automatic power(input logic f, input logic [2:0] wa,
		input logic [2:0] wk);
		xfer(1'b1, IDX_POWER_LEVEL, {f, wa, 1'b1, wk});
	endtask

	// x bit0 first, then y with bit7
	task automatic drive(input logic [1:0] xd, input logic [1:0] yd);
		xfer(1'b1, IDX_X_TEST_DRIVE, {4'h0, xd, 2'b01});
		xfer(1'b1, IDX_Y_TEST_DRIVE, {4'h8, yd, 2'b00});
	endtask
endmodule

//--- aps_power_selftest_regs_bench.sv
`timescale 1ns/1ps
module aps_power_selftest_regs_bench;
	import aps_pkg::*;
	// stimulus
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic modeLoad = 1'b0;
	logic activityPin = 1'b0;
	logic [2:0] modeCode = 3'h0;
	// bus and device side
	logic psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	aps_mode_t operatingMode;
	aps_levels_t powerLevels;
	aps_drive_t testDrive;
	logic fastSerialEnable;
	logic [REG_W-1:0] startupFixup;
	logic [2:0] lv [3] = '{LVL_LOW, LVL_ULTRA_LOW, LVL_PRECISION};
	int err_total = 0;
	int total_checks = 0;

	// 25 MHz
	always #20 clk = ~clk;

	aps_power_selftest_regs aps_power_selftest_regs_inst (.clk, .srst,
		.ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .modeCode, .modeLoad,
		.activityPin, .operatingMode, .powerLevels, .testDrive,
		.fastSerialEnable, .startupFixup);
	aps_host aps_host_inst (.clk, .prdata, .pready, .pslverr, .psel,
		.penable, .pwrite, .paddr, .pwdata);

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read through the host, then compare
	task automatic rdk(input logic [7:0] idx, input logic [31:0] exp);
		aps_host_inst.xfer(1'b0, idx, 8'h00);
		chk(aps_host_inst.q, exp);
	endtask

	// mode shows one edge after the load pulse
	task automatic setMode(input logic [2:0] c);
		modeCode <= c;
		modeLoad <= 1'b1;
		@(posedge clk);
		modeLoad <= 1'b0;
		@(posedge clk);
	endtask

	// verdict
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog, well past the roughly 140 cycles needed
	initial begin
		#200000;
		err_total++;
		summarize();
	end

	// tests
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		aps_host_inst.xfer(1'b1, IDX_STARTUP_FIXUP, 8'h00);
		chk({24'h0, startupFixup}, 32'h0);
		rdk(IDX_POWER_LEVEL, 32'h0);
		chk({31'h0, aps_host_inst.e}, 32'h0);
		chk({31'h0, fastSerialEnable}, 32'h0);
		rdk(IDX_Y_TEST_DRIVE, 32'h0);
		chk({28'h0, testDrive}, 32'h0);
		aps_host_inst.xfer(1'b1, IDX_FREE_STORAGE, 8'hA5);
		rdk(IDX_FREE_STORAGE, 32'hA5);
		chk({23'h0, powerLevels}, 32'h0);
		$display("test reset and storage done");
		foreach (lv[i]) begin
			aps_host_inst.power(1'b0, lv[2-i], lv[i]);
			rdk(IDX_POWER_LEVEL, {25'h0, lv[2-i], 1'b0, lv[i]});
			chk({23'h0, powerLevels}, {23'h0, lv[i], lv[2-i], 3'h0});
		end
		aps_host_inst.power(1'b1, LVL_LOW, LVL_PRECISION);
		chk({31'h0, fastSerialEnable}, 32'h1);
		rdk(IDX_POWER_LEVEL, 32'h4);
		$display("test power levels done");
		aps_host_inst.drive(2'b01, 2'b10);
		chk({28'h0, testDrive}, 32'h9);
		aps_host_inst.drive(2'b10, 2'b01);
		chk({28'h0, testDrive}, 32'h6);
		rdk(IDX_X_TEST_DRIVE, 32'h0);
		$display("test drive done");
		for (int m = 0; m < 6; m++) begin
			setMode(3'(m));
			rdk(IDX_Y_TEST_DRIVE, (m < 2) ? 32'h0 : 32'h80);
		end
		setMode(MODE_CODE_WATCH);
		chk({23'h0, powerLevels}, 32'h100);
		activityPin <= 1'b1;
		repeat (6) @(posedge clk);
		chk({29'h0, operatingMode}, {29'h0, MODE_CONTINUOUS_WAKE_MODE});
		chk({23'h0, powerLevels}, 32'h104);
		rdk(8'h1D, 32'h0);
		chk({31'h0, aps_host_inst.e}, 32'h1);
		aps_host_inst.xfer(1'b1, 8'h1D, 8'hFF);
		chk({31'h0, aps_host_inst.e}, 32'h1);
		rdk(IDX_FREE_STORAGE, 32'hA5);
		// ce low must swallow a mode load pulse
		ce <= 1'b0;
		setMode(MODE_CODE_SLEEP);
		chk({29'h0, operatingMode}, {29'h0, MODE_CONTINUOUS_WAKE_MODE});
		ce <= 1'b1;
		setMode(MODE_CODE_SLEEP);
		chk({29'h0, operatingMode}, {29'h0, MODE_SLEEP});
		$display("test modes and unmapped done");
		summarize();
	end
endmodule
